// ===== rtl/octx_pkg.sv
// Shared constants for the octal inverting bus register transceiver
package octx_pkg;
  localparam int OCTX_DATA_W = 8;
  localparam int OCTX_APB_AW = 8;
  localparam int OCTX_APB_DW = 32;
  localparam int OCTX_CTRL_W = 5;

  // Register byte offsets
  localparam logic [7:0] OCTX_CTRL_OFS = 8'h00;
  localparam logic [7:0] OCTX_STATUS_OFS = 8'h04;
  localparam logic [7:0] OCTX_DATA_OFS = 8'h08;
  localparam logic [7:0] OCTX_STROBE_OFS = 8'h0C;
  localparam logic [1:0] OCTX_WORD_ALIGN = 2'h0;

  // Control register fields
  localparam int OCTX_CTRL_SW_BIT = 0;
  localparam int OCTX_CTRL_OE_N_BIT = 1;
  localparam int OCTX_CTRL_DIR_BIT = 2;
  localparam int OCTX_CTRL_AB_SEL_BIT = 3;
  localparam int OCTX_CTRL_BA_SEL_BIT = 4;
  localparam logic [OCTX_CTRL_W-1:0] OCTX_CTRL_RST = 5'h02;

  // Strobe register fields
  localparam int OCTX_STB_CAP_A_BIT = 0;
  localparam int OCTX_STB_CAP_B_BIT = 1;

  // Status register fields
  localparam int OCTX_ST_DRV_A_BIT = 0;
  localparam int OCTX_ST_DRV_B_BIT = 1;
  localparam int OCTX_ST_OE_N_BIT = 2;
  localparam int OCTX_ST_DIR_BIT = 3;
  localparam int OCTX_ST_AB_SEL_BIT = 4;
  localparam int OCTX_ST_BA_SEL_BIT = 5;
  localparam int OCTX_ST_AB_CLK_BIT = 6;
  localparam int OCTX_ST_BA_CLK_BIT = 7;

  // Data register fields
  localparam int OCTX_DATA_A_LSB = 0;
  localparam int OCTX_DATA_B_LSB = 8;

  localparam logic OCTX_CLK_IDLE = 1'b1;
  localparam logic [OCTX_DATA_W-1:0] OCTX_STORE_RST = 8'h00;
  localparam logic [OCTX_APB_DW-1:0] OCTX_RDATA_RST = 32'h0000_0000;
endpackage : octx_pkg

// ===== rtl/octx_cap_if.sv
// Carrier between the transceiver top and one capture register
`timescale 1ns/100ps
interface octx_cap_if #(parameter int W = 8);
  logic clk_pin;
  logic soft_cap;
  logic [W-1:0] bus_in;
  logic [W-1:0] stored;
  logic [W-1:0] stored_nxt;
  logic cap_ev;
  modport cap (input clk_pin, input soft_cap, input bus_in,
               output stored, output stored_nxt, output cap_ev);
  modport user (output clk_pin, output soft_cap, output bus_in,
                input stored, input stored_nxt, input cap_ev);
endinterface : octx_cap_if

// ===== rtl/octx_capture.sv
// One direction's capture register, loaded on a rising edge of its clock pin
`timescale 1ns/100ps
module octx_capture #(
  parameter int W = octx_pkg::OCTX_DATA_W
) (
  input wire logic mclk,
  input wire logic nrst,
  octx_cap_if.cap cap
);
  import octx_pkg::*;

  logic prev_r;
  logic [W-1:0] stored_r;
  logic cap_ev;

  // Capture ignores drive enable and direction entirely
  assign cap_ev = (cap.clk_pin & ~prev_r) | cap.soft_cap;
  assign cap.stored_nxt = cap_ev ? cap.bus_in : stored_r;
  assign cap.stored = stored_r;
  assign cap.cap_ev = cap_ev;

  // Idle-high reset keeps a pin already high at release from faking an edge
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prev_r <= OCTX_CLK_IDLE;
    end else begin
      prev_r <= cap.clk_pin;
    end
  end

  // Contents hold while the clock pin stays static and no software strobe arrives
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stored_r <= W'(OCTX_STORE_RST);
    end else begin
      stored_r <= cap.stored_nxt;
    end
  end
endmodule : octx_capture

// ===== rtl/octx_transceiver.sv
// Octal inverting bus register transceiver with APB control and status
//
// Functional notes
// - Eight two-way lines on each port, one eight-bit register per direction.
// - Rising A-to-B clock loads port A; rising B-to-A clock loads port B.
// - Capture works whatever drive enable and direction are, even on driven port.
// - Drive enable high: no port driven, registers load or hold by clock.
// - Enabled, direction low: port A gets inverted live B or stored B.
// - Enabled, direction high: port B gets inverted live A or stored A.
// - Every driven value is the bitwise complement of its source.
// - Direction picks the receiving port only while drive is enabled.
// - At most one port driven; outside logic avoids the driven port.
// - Undriven port keeps its input path for capture and pass-through.
`timescale 1ns/100ps
module octx_transceiver #(
  parameter int DATA_W = octx_pkg::OCTX_DATA_W
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [octx_pkg::OCTX_APB_AW-1:0] paddr,
  input wire logic [octx_pkg::OCTX_APB_DW-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [octx_pkg::OCTX_APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic drive_en_n,
  input wire logic dir,
  input wire logic a_to_b_clock,
  input wire logic b_to_a_clock,
  input wire logic a_to_b_source_select,
  input wire logic b_to_a_source_select,
  input wire logic [DATA_W-1:0] port_a_i,
  output logic [DATA_W-1:0] port_a_o,
  output logic port_a_oe,
  input wire logic [DATA_W-1:0] port_b_i,
  output logic [DATA_W-1:0] port_b_o,
  output logic port_b_oe
);
  import octx_pkg::*;

  // APB side
  logic apb_acc;
  logic apb_done;
  logic addr_ok;
  logic hit_ctrl;
  logic hit_status;
  logic hit_data;
  logic hit_strobe;
  logic pready_r;
  logic pslverr_r;
  logic [OCTX_APB_DW-1:0] prdata_r;
  logic [OCTX_APB_DW-1:0] rdata_nxt;
  logic [OCTX_CTRL_W-1:0] ctrl_r;

  // Effective controls and drive path
  logic sw_ctl;
  logic eff_oe_n;
  logic eff_dir;
  logic eff_ab_sel;
  logic eff_ba_sel;
  logic drive_a_nxt;
  logic drive_b_nxt;
  logic [DATA_W-1:0] a_src;
  logic [DATA_W-1:0] b_src;
  logic [DATA_W-1:0] port_a_o_r;
  logic [DATA_W-1:0] port_b_o_r;
  logic port_a_oe_r;
  logic port_b_oe_r;

  octx_cap_if #(.W(DATA_W)) a_if ();
  octx_cap_if #(.W(DATA_W)) b_if ();

  // ---------------------------------------------------------------------
  // Register bus slave: one wait state, so every access is answered alike
  // ---------------------------------------------------------------------
  assign apb_acc = psel & penable;
  assign apb_done = apb_acc & pready_r;
  assign addr_ok = (paddr[1:0] == OCTX_WORD_ALIGN);
  assign hit_ctrl = addr_ok & (paddr == OCTX_CTRL_OFS);
  assign hit_status = addr_ok & (paddr == OCTX_STATUS_OFS);
  assign hit_data = addr_ok & (paddr == OCTX_DATA_OFS);
  assign hit_strobe = addr_ok & (paddr == OCTX_STROBE_OFS);

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pready_r <= 1'b0;
    end else begin
      pready_r <= apb_acc & ~pready_r;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pslverr_r <= 1'b0;
    end else begin
      pslverr_r <= apb_acc & ~pready_r &
                   ~(hit_ctrl | hit_status | hit_data | hit_strobe);
    end
  end

  always_comb begin
    rdata_nxt = OCTX_RDATA_RST;
    if (hit_ctrl) begin
      rdata_nxt[OCTX_CTRL_W-1:0] = ctrl_r;
    end else if (hit_status) begin
      rdata_nxt[OCTX_ST_DRV_A_BIT] = port_a_oe_r;
      rdata_nxt[OCTX_ST_DRV_B_BIT] = port_b_oe_r;
      rdata_nxt[OCTX_ST_OE_N_BIT] = drive_en_n;
      rdata_nxt[OCTX_ST_DIR_BIT] = dir;
      rdata_nxt[OCTX_ST_AB_SEL_BIT] = a_to_b_source_select;
      rdata_nxt[OCTX_ST_BA_SEL_BIT] = b_to_a_source_select;
      rdata_nxt[OCTX_ST_AB_CLK_BIT] = a_to_b_clock;
      rdata_nxt[OCTX_ST_BA_CLK_BIT] = b_to_a_clock;
    end else if (hit_data) begin
      rdata_nxt[OCTX_DATA_A_LSB +: DATA_W] = a_if.stored;
      rdata_nxt[OCTX_DATA_B_LSB +: DATA_W] = b_if.stored;
    end
  end

  // Read data is sampled one cycle before the master takes it
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      prdata_r <= OCTX_RDATA_RST;
    end else if (apb_acc & ~pready_r & ~pwrite) begin
      prdata_r <= rdata_nxt;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      ctrl_r <= OCTX_CTRL_RST;
    end else if (apb_done & pwrite & hit_ctrl & pstrb[0]) begin
      ctrl_r <= pwdata[OCTX_CTRL_W-1:0];
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;

  // ---------------------------------------------------------------------
  // Control source: pins, or the control register when software owns it
  // ---------------------------------------------------------------------
  assign sw_ctl = ctrl_r[OCTX_CTRL_SW_BIT];
  assign eff_oe_n = sw_ctl ? ctrl_r[OCTX_CTRL_OE_N_BIT] : drive_en_n;
  assign eff_dir = sw_ctl ? ctrl_r[OCTX_CTRL_DIR_BIT] : dir;
  assign eff_ab_sel = sw_ctl ? ctrl_r[OCTX_CTRL_AB_SEL_BIT] : a_to_b_source_select;
  assign eff_ba_sel = sw_ctl ? ctrl_r[OCTX_CTRL_BA_SEL_BIT] : b_to_a_source_select;

  // ---------------------------------------------------------------------
  // Capture registers; clock pins and software strobes both load them
  // ---------------------------------------------------------------------
  assign a_if.clk_pin = a_to_b_clock;
  assign a_if.bus_in = port_a_i;
  assign a_if.soft_cap = apb_done & pwrite & hit_strobe & pstrb[0] &
                         pwdata[OCTX_STB_CAP_A_BIT];
  assign b_if.clk_pin = b_to_a_clock;
  assign b_if.bus_in = port_b_i;
  assign b_if.soft_cap = apb_done & pwrite & hit_strobe & pstrb[0] &
                         pwdata[OCTX_STB_CAP_B_BIT];

  octx_capture #(.W(DATA_W)) u_cap_a (
    .mclk (mclk),
    .nrst (nrst),
    .cap (a_if.cap)
  );

  octx_capture #(.W(DATA_W)) u_cap_b (
    .mclk (mclk),
    .nrst (nrst),
    .cap (b_if.cap)
  );

  // ---------------------------------------------------------------------
  // Drive path; the decode can never enable both ports together
  // ---------------------------------------------------------------------
  assign drive_a_nxt = ~eff_oe_n & ~eff_dir;
  assign drive_b_nxt = ~eff_oe_n & eff_dir;

  // Stored source uses the next register value so a fresh capture appears at once
  assign a_src = eff_ba_sel ? b_if.stored_nxt : port_b_i;
  assign b_src = eff_ab_sel ? a_if.stored_nxt : port_a_i;

  // Outputs are registered, which costs one mclk of real-time latency
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port_a_oe_r <= 1'b0;
      port_b_oe_r <= 1'b0;
    end else begin
      port_a_oe_r <= drive_a_nxt;
      port_b_oe_r <= drive_b_nxt;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      port_a_o_r <= ~DATA_W'(OCTX_STORE_RST);
      port_b_o_r <= ~DATA_W'(OCTX_STORE_RST);
    end else begin
      port_a_o_r <= ~a_src;
      port_b_o_r <= ~b_src;
    end
  end

  assign port_a_o = port_a_o_r;
  assign port_b_o = port_b_o_r;
  assign port_a_oe = port_a_oe_r;
  assign port_b_oe = port_b_oe_r;

  // ---------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  sequence s_iso;
    eff_oe_n;
  endsequence

  sequence s_to_a;
    !eff_oe_n && !eff_dir;
  endsequence

  sequence s_to_b;
    !eff_oe_n && eff_dir;
  endsequence

  sequence s_b_pulls_a;
    s_to_b ##0 a_if.cap_ev;
  endsequence

  one_driver_a: assert property (!(port_a_oe && port_b_oe))
    else $error("both ports driven at once");

  a_capture_a: assert property (a_if.cap_ev |=> a_if.stored == $past(port_a_i))
    else $error("A register did not load port A");

  b_capture_a: assert property (b_if.cap_ev |=> b_if.stored == $past(port_b_i))
    else $error("B register did not load port B");

  pin_edge_a: assert property ($rose(a_to_b_clock) && $past(nrst) |-> a_if.cap_ev)
    else $error("rising A-to-B clock missed");

  store_hold_a: assert property (!a_if.cap_ev && !b_if.cap_ev |=>
    $stable(a_if.stored) && $stable(b_if.stored))
    else $error("register changed without a clock");

  isolate_both_a: assert property (s_iso |=> !port_a_oe && !port_b_oe)
    else $error("port driven while drive disabled");

  live_to_a_a: assert property (s_to_a ##0 !eff_ba_sel |=>
    port_a_oe && port_a_o == ~$past(port_b_i))
    else $error("port A not inverted live B");

  stored_to_a_a: assert property (s_to_a ##0 eff_ba_sel |=>
    port_a_o == ~b_if.stored)
    else $error("port A not inverted stored B");

  live_to_b_a: assert property (s_to_b ##0 !eff_ab_sel |=>
    port_b_oe && port_b_o == ~$past(port_a_i))
    else $error("port B not inverted live A");

  stored_to_b_a: assert property (s_to_b ##0 eff_ab_sel |=>
    port_b_o == ~a_if.stored)
    else $error("port B not inverted stored A");

  dir_pick_a: assert property (s_to_b |=> port_b_oe && !port_a_oe)
    else $error("direction high did not drive port B only");

  input_live_a: assert property (s_b_pulls_a |=>
    a_if.stored == $past(port_a_i) && port_b_oe)
    else $error("port A capture lost while B driven");

  apb_wait_a: assert property (apb_acc && !pready |=> pready ##1 !pready)
    else $error("APB answer not one wait state");

endmodule : octx_transceiver

// ===== verif/octx_bus_model.sv
// Outside logic on one parallel bus, resolving the bus level with the device drive
`timescale 1ns/100ps
module octx_bus_model (
  input wire logic mclk,
  input wire logic [7:0] dev_o,
  input wire logic dev_oe,
  input wire logic [7:0] ext_val,
  input wire logic ext_en,
  output logic [7:0] level
);
  logic [7:0] last_r;
  // Outside logic backs off while the device drives the bus
  // A floating bus toggles so a stale value can never pass for a real one
  assign level = dev_oe ? dev_o : (ext_en ? ext_val : ~last_r);
  always_ff @(posedge mclk) begin
    last_r <= level;
  end
endmodule : octx_bus_model

// ===== verif/octx_transceiver_bench.sv
// Self-checking bench for the inverting bus register transceiver
`timescale 1ns/100ps
module octx_transceiver_bench;
  import octx_pkg::*;
  logic mclk = 1'h0;
  logic nrst = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready;
  logic pslverr;
  logic err;
  logic en_n = 1'h1;
  logic dir = 1'h0;
  logic ab_clk = 1'h1;
  logic ba_clk = 1'h1;
  logic ab_sel = 1'h0;
  logic ba_sel = 1'h0;
  logic [7:0] a_lvl, b_lvl, a_o, b_o;
  logic [7:0] a_ext = 8'h00;
  logic [7:0] b_ext = 8'h00;
  logic a_oe, b_oe;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;

  always #2.5 mclk = ~mclk;

  octx_transceiver uut (.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .drive_en_n(en_n), .dir(dir),
    .a_to_b_clock(ab_clk), .b_to_a_clock(ba_clk), .a_to_b_source_select(ab_sel),
    .b_to_a_source_select(ba_sel), .port_a_i(a_lvl), .port_a_o(a_o), .port_a_oe(a_oe),
    .port_b_i(b_lvl), .port_b_o(b_o), .port_b_oe(b_oe));
  octx_bus_model bus_a (.mclk(mclk), .dev_o(a_o), .dev_oe(a_oe), .ext_val(a_ext),
    .ext_en(1'h1), .level(a_lvl));
  octx_bus_model bus_b (.mclk(mclk), .dev_o(b_o), .dev_oe(b_oe), .ext_val(b_ext),
    .ext_en(1'h1), .level(b_lvl));

  task summarize;
    if (bad_count == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  // Run-time ceiling well above the hundred or so cycles the sequence needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 4000) begin
      bad_count++;
      summarize();
    end
  end

  task chk(input logic [32:0] seen, input logic [32:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'h1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) bad_count++;
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle

  // Capture pins idle high; the device needs a fresh low-to-high step
  task pulse(input logic ab, input logic ba);
    @(posedge mclk);
    ab_clk <= ~ab;
    ba_clk <= ~ba;
    repeat (2) @(posedge mclk);
    ab_clk <= 1'h1;
    ba_clk <= 1'h1;
    settle();
  endtask : pulse

  initial begin
    repeat (2) @(posedge mclk);
    nrst <= 1'h1;
    settle();
    apb(1'h0, OCTX_CTRL_OFS, 32'h0);
    chk({err, rd}, 33'h2);
    chk({a_oe, b_oe}, 33'h0);
    @(posedge mclk);
    a_ext <= 8'h3C;
    b_ext <= 8'hA5;
    pulse(1'h1, 1'h1);
    apb(1'h0, OCTX_DATA_OFS, 32'h0);
    chk(rd, 33'hA53C);
    chk({a_oe, b_oe}, 33'h0);
    @(posedge mclk);
    en_n <= 1'h0;
    b_ext <= 8'h81;
    settle();
    chk({a_oe, b_oe}, 33'h2);
    chk(a_o, 33'h7E);
    @(posedge mclk);
    ba_sel <= 1'h1;
    settle();
    chk(a_o, 33'h5A);
    @(posedge mclk);
    b_ext <= 8'h0F;
    pulse(1'h0, 1'h1);
    chk(a_o, 33'hF0);
    // Port A is driven here, so its register takes the device's own drive
    pulse(1'h1, 1'h0);
    apb(1'h0, OCTX_DATA_OFS, 32'h0);
    chk(rd, 33'h0FF0);
    @(posedge mclk);
    dir <= 1'h1;
    a_ext <= 8'h96;
    settle();
    chk({a_oe, b_oe}, 33'h1);
    chk(b_o, 33'h69);
    @(posedge mclk);
    ab_sel <= 1'h1;
    settle();
    chk(b_o, 33'h0F);
    @(posedge mclk);
    en_n <= 1'h1;
    settle();
    chk({a_oe, b_oe}, 33'h0);
    @(posedge mclk);
    dir <= 1'h0;
    ab_sel <= 1'h0;
    ba_sel <= 1'h0;
    a_ext <= 8'h33;
    apb(1'h1, OCTX_CTRL_OFS, 32'h5);
    settle();
    chk({err, b_o}, 33'hCC);
    apb(1'h0, OCTX_STATUS_OFS, 32'h0);
    chk(rd, 33'hC6);
    apb(1'h1, OCTX_STROBE_OFS, 32'h1);
    apb(1'h0, OCTX_DATA_OFS, 32'h0);
    chk(rd[7:0], 33'h33);
    apb(1'h0, OCTX_STROBE_OFS, 32'h0);
    chk({err, rd}, 33'h0);
    apb(1'h1, OCTX_CTRL_OFS, 32'h2);
    settle();
    chk({a_oe, b_oe}, 33'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk({err, rd}, 33'h100000000);
    apb(1'h1, 8'h02, 32'h5);
    apb(1'h0, OCTX_CTRL_OFS, 32'h0);
    chk(rd, 33'h2);
    summarize();
  end
endmodule : octx_transceiver_bench
